// >>> logic/odppi_params.svh
// Purpose: constants for the octal DDR pin interface
// Assumes: included by bare name from the design files
// Notes:   latency counts are in whole bus clocks
`ifndef ODPPI_PARAMS_SVH
`define ODPPI_PARAMS_SVH

// opcodes that steer the data phase
`define ODPPI_OP_READ     8'hEE
`define ODPPI_OP_RDREG    8'h65
`define ODPPI_OP_RDID     8'h9F
`define ODPPI_OP_WRITE    8'hDE
`define ODPPI_OP_WRREG    8'h71

// index of the last of the two address words after the command word
`define ODPPI_ADDR_LAST   2'h1

// initial latency, one count and two counts
`define ODPPI_LAT_1X      5'h06
`define ODPPI_LAT_2X      (`ODPPI_LAT_1X + `ODPPI_LAT_1X)
`define ODPPI_LAT_DONE    5'h01

// read data buffer shape
`define ODPPI_FIFO_WIDTH  16
`define ODPPI_FIFO_DEPTH  16

`endif

// >>> logic/odppi_pkg.sv
// Purpose: shared types of the octal DDR pin interface
// Assumes: nothing
// Notes:   constants live in odppi_params.svh
`default_nettype none

package odppi_pkg;

   // link sequencer states
   typedef enum logic [2:0] {
      ST_CMD,
      ST_ADDR,
      ST_LAT,
      ST_RD,
      ST_WR,
      ST_IDLE
   } odppi_state_t;

   // command and address of one transaction
   typedef struct packed {
      logic [7:0]  cmd;
      logic [31:0] addr;
   } odppi_ca_t;

   // one received write word; mask high means keep the byte
   typedef struct packed {
      logic [31:0] addr;
      logic [15:0] data;
      logic [1:0]  mask;
   } odppi_wr_t;

endpackage : odppi_pkg

`default_nettype wire

// >>> logic/odppi_fifo.sv
// Purpose: synchronous FIFO with registered flags
// Assumes: DEPTH is a power of two
// Notes:   ready and valid come straight from flops
`default_nettype none

module odppi_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   // clock and control
   input  wire logic             i_clk,
   input  wire logic             i_reset,
   input  wire logic             i_clk_en,
   input  wire logic             i_flush,
   // fill side
   input  wire logic             i_valid,
   output logic                  o_ready,
   input  wire logic [WIDTH-1:0] i_data,
   // drain side
   output logic                  o_valid,
   input  wire logic             i_ready,
   output logic [WIDTH-1:0]      o_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_idx_reg;
   logic [AW-1:0]    rd_idx_reg;
   logic [AW:0]      cnt_reg;
   logic [AW:0]      cnt_next;
   logic             push;
   logic             pop;

   assign push = i_valid & o_ready;
   assign pop  = i_ready & o_valid;
   assign o_data = mem_reg[rd_idx_reg];

   // occupancy after this cycle
   always_comb begin
      cnt_next = cnt_reg;
      if (push && !pop) begin
         cnt_next = cnt_reg + 1'b1;
      end else if (pop && !push) begin
         cnt_next = cnt_reg - 1'b1;
      end
   end

   // storage, no reset needed on data
   always_ff @(posedge i_clk) begin
      if (i_clk_en && push) begin
         mem_reg[wr_idx_reg] <= i_data;
      end
   end

   // pointers and flags; flags are registered from the next count
   always_ff @(posedge i_clk) begin
      if (i_reset || (i_clk_en && i_flush)) begin
         wr_idx_reg <= '0;
         rd_idx_reg <= '0;
         cnt_reg    <= '0;
         o_ready    <= 1'b1;
         o_valid    <= 1'b0;
      end else if (i_clk_en) begin
         if (push) wr_idx_reg <= wr_idx_reg + 1'b1;
         if (pop)  rd_idx_reg <= rd_idx_reg + 1'b1;
         cnt_reg <= cnt_next;
         o_ready <= (cnt_next != (AW+1)'(DEPTH));
         o_valid <= (cnt_next != '0);
      end
   end

endmodule : odppi_fifo

`default_nettype wire

// >>> logic/odppi_pin_if.sv
// Purpose: device side of an octal DDR pseudo-static memory port
// Assumes: bus clock much slower than i_clk (160 ns vs 4 ns)
// Notes:   link logic runs on both bus clock edges, user side on i_clk
//
// Notes on behaviour
// - falling chip select starts a fresh transaction.
// - rising chip select ends any transaction in progress at once.
// - differential mode: transfers use the true/complement crossing.
// - single-ended mode: complement clock ignored, true clock used.
// - bus clock may stop outside transactions; the refresh flag then keeps its level from the last frame.
// - command, address and data share the eight data lines.
// - strobe driven during command/address: high asks extra latency.
// - read data driven edge aligned with strobe transitions.
// - strobe is a host-driven byte mask in write data phase.
// - hardware reset low reinitialises device to standby.
// - hardware reset low releases strobe and data lines.
// - transfers happen on both rising and falling clock edges.
// - one latency count if strobe low, two if high.
// - masked write bytes leave the array unchanged.
`default_nettype none

`include "odppi_params.svh"

module odppi_pin_if
   import odppi_pkg::*;
(
   // system clock and control
   input  wire logic        i_clk,
   input  wire logic        i_reset,
   input  wire logic        i_clk_en,
   // memory pins
   input  wire logic        i_bus_clock_true,
   input  wire logic        i_bus_clock_complement,
   input  wire logic        i_chip_select_n,
   input  wire logic        i_hw_reset_n,
   input  wire logic [7:0]  i_dq,
   output logic      [7:0]  o_dq,
   output logic             o_dq_oe,
   input  wire logic        i_read_write_strobe,
   output logic             o_read_write_strobe,
   output logic             o_read_write_strobe_oe,
   // array side: refresh request and command report
   input  wire logic        i_refresh_pending,
   output odppi_ca_t        o_cmd,
   output logic             o_cmd_valid,
   // array side: write words
   output odppi_wr_t        o_wr,
   output logic             o_wr_valid,
   // array side: read words
   input  wire logic [15:0] i_rd_data,
   input  wire logic        i_rd_valid,
   output logic             o_rd_ready,
   // status
   output logic             o_busy,
   output logic             o_standby,
   output logic             o_read_underrun
);
   // ---------------- link domain ----------------
   logic         link_clear;
   logic         link_rst;
   odppi_state_t state_reg;
   logic [7:0]   cmd_reg;
   logic [31:0]  addr_reg;
   logic [1:0]   wcnt_reg;
   logic [4:0]   lat_reg;
   logic         rd_cmd_reg;
   logic         rd_sel_reg;
   logic [7:0]   pos_byte_reg;
   logic         pos_mask_reg;
   logic [7:0]   dq_pos_reg;
   logic [7:0]   dq_neg_reg;
   logic         str_pos_reg;
   logic         str_neg_reg;
   logic         dq_oe_reg;
   logic         str_oe_reg;
   logic         ca_tog_reg;
   logic         wr_tog_reg;
   odppi_wr_t    wr_word_reg;
   logic [1:0]   cons_tog_reg;
   logic         underrun_reg;
   logic         refr_s1_reg;
   logic         refr_s2_reg;
   logic [1:0]   fill_s1_reg;
   logic [1:0]   fill_s2_reg;

   // ---------------- system domain ----------------
   logic         sys_rst;
   logic         cs_s1_reg, cs_s2_reg;
   logic         hw_s1_reg, hw_s2_reg;
   logic         ca_s1_reg, ca_s2_reg, ca_s3_reg;
   logic         wr_s1_reg, wr_s2_reg, wr_s3_reg;
   logic [1:0]   cons_s1_reg, cons_s2_reg;
   logic         und_s1_reg, und_s2_reg;
   logic         reading_reg;
   logic         fill_sel_reg;
   logic [1:0]   fill_tog_reg;
   logic [15:0]  slot_reg [2];
   logic         fifo_valid;
   logic [15:0]  fifo_data;
   logic         fifo_pop;

   // read-type opcodes stream data out of the device
   function automatic logic is_read(input logic [7:0] op);
      is_read = (op == `ODPPI_OP_READ) || (op == `ODPPI_OP_RDREG) ||
                (op == `ODPPI_OP_RDID);
   endfunction : is_read

   // chip select high or reset low ends the frame without needing a clock edge
   assign link_clear = i_chip_select_n | ~i_hw_reset_n;
   assign link_rst   = ~i_hw_reset_n;

   // the complement clock only matters on the analogue receiver; in both
   // modes its crossing coincides with the true clock edges used here

   // ddr output mux: each half cycle shows the byte launched on its edge
   assign o_dq                = i_bus_clock_true ? dq_pos_reg : dq_neg_reg;
   assign o_read_write_strobe = i_bus_clock_true ? str_pos_reg : str_neg_reg;
   assign o_dq_oe                = dq_oe_reg;
   assign o_read_write_strobe_oe = str_oe_reg;

   // refresh request and slot fill flags into the link domain; rising then
   // falling edge keeps two flops while saving half a bus cycle
   always_ff @(posedge i_bus_clock_true or posedge link_rst) begin
      if (link_rst) begin
         refr_s1_reg <= 1'b0;
         fill_s1_reg <= 2'h0;
      end else begin
         refr_s1_reg <= i_refresh_pending;
         fill_s1_reg <= fill_tog_reg;
      end
   end

   always_ff @(negedge i_bus_clock_true or posedge link_rst) begin
      if (link_rst) begin
         refr_s2_reg <= 1'b0;
         fill_s2_reg <= 2'h0;
      end else begin
         refr_s2_reg <= refr_s1_reg;
         fill_s2_reg <= fill_s1_reg;
      end
   end

   // rising edge: first byte of a word in, high byte out, data driver on
   always_ff @(posedge i_bus_clock_true or posedge link_clear) begin
      if (link_clear) begin
         pos_byte_reg <= 8'h00;
         pos_mask_reg <= 1'b0;
         dq_pos_reg   <= 8'h00;
         str_pos_reg  <= 1'b0;
         dq_oe_reg    <= 1'b0;
      end else begin
         pos_byte_reg <= i_dq;
         pos_mask_reg <= i_read_write_strobe;
         case (state_reg)
            ST_CMD: begin
               str_pos_reg <= refr_s2_reg;
            end
            ST_LAT: begin
               str_pos_reg <= 1'b0;
            end
            ST_RD: begin
               dq_pos_reg  <= slot_reg[rd_sel_reg][15:8];
               str_pos_reg <= 1'b1;
               dq_oe_reg   <= 1'b1;
            end
            default: begin
               dq_oe_reg  <= 1'b0;
            end
         endcase
      end
   end

   // falling edge: sequencer; cleared by the frame's own select
   always_ff @(negedge i_bus_clock_true or posedge link_clear) begin
      if (link_clear) begin
         state_reg   <= ST_CMD;
         wcnt_reg    <= 2'h0;
         lat_reg     <= 5'h00;
         rd_sel_reg  <= 1'b0;
         dq_neg_reg  <= 8'h00;
         str_neg_reg <= 1'b0;
         str_oe_reg  <= 1'b0;
      end else begin
         str_neg_reg <= str_pos_reg;
         case (state_reg)
            ST_CMD: begin
               state_reg  <= ST_ADDR;
               wcnt_reg   <= 2'h0;
               str_oe_reg <= 1'b1;
            end
            ST_ADDR: begin
               wcnt_reg <= wcnt_reg + 2'h1;
               if (wcnt_reg == `ODPPI_ADDR_LAST) begin
                  // latency doubles when refresh was flagged
                  lat_reg <= str_pos_reg ? `ODPPI_LAT_2X : `ODPPI_LAT_1X;
                  str_oe_reg <= rd_cmd_reg;  // off before the first mask rise
                  if (cmd_reg == `ODPPI_OP_WRREG) begin
                     state_reg <= ST_WR;
                  end else if (is_read(cmd_reg) || cmd_reg == `ODPPI_OP_WRITE) begin
                     state_reg <= ST_LAT;
                  end else begin
                     state_reg <= ST_IDLE;
                  end
               end
            end
            ST_LAT: begin
               lat_reg <= lat_reg - 5'h01;
               if (lat_reg == `ODPPI_LAT_DONE) begin
                  state_reg <= rd_cmd_reg ? ST_RD : ST_WR;
               end
            end
            ST_RD: begin
               dq_neg_reg  <= slot_reg[rd_sel_reg][7:0];
               str_neg_reg <= 1'b0;
               rd_sel_reg  <= ~rd_sel_reg;
            end
            default: begin
               state_reg  <= state_reg;
               str_oe_reg <= 1'b0;
            end
         endcase
      end
   end

   // falling edge: words that cross to the system side; toggles survive
   // chip select so the far side never sees a false event
   always_ff @(negedge i_bus_clock_true or posedge link_rst) begin
      if (link_rst) begin
         cmd_reg      <= 8'h00;
         addr_reg     <= 32'h0000_0000;
         rd_cmd_reg   <= 1'b0;
         ca_tog_reg   <= 1'b0;
         wr_tog_reg   <= 1'b0;
         wr_word_reg  <= '0;
         cons_tog_reg <= 2'h0;
         underrun_reg <= 1'b0;
      end else begin
         if (state_reg == ST_CMD) begin
            cmd_reg    <= pos_byte_reg;  // opcode repeats on both edges
            rd_cmd_reg <= is_read(pos_byte_reg);
         end
         if (state_reg == ST_ADDR) begin
            addr_reg <= {addr_reg[15:0], pos_byte_reg, i_dq};  // msb first
            if (wcnt_reg == `ODPPI_ADDR_LAST) begin
               ca_tog_reg <= ~ca_tog_reg;
               wr_word_reg.addr <= {addr_reg[15:0], pos_byte_reg, i_dq};
            end
         end
         if (state_reg == ST_WR) begin
            wr_word_reg.data <= {pos_byte_reg, i_dq};  // first byte on rise
            wr_word_reg.mask <= {pos_mask_reg, i_read_write_strobe};
            wr_tog_reg <= ~wr_tog_reg;
         end
         if (state_reg == ST_RD) begin
            cons_tog_reg[rd_sel_reg] <= ~cons_tog_reg[rd_sel_reg];
            // slot not refilled in time: stale word went out
            if (fill_s2_reg[rd_sel_reg] == cons_tog_reg[rd_sel_reg]) begin
               underrun_reg <= 1'b1;
            end
         end
      end
   end

   // ---------------- system domain ----------------
   assign sys_rst  = i_reset | ~hw_s2_reg;
   assign fifo_pop = i_clk_en & reading_reg & fifo_valid &
                     (fill_tog_reg[fill_sel_reg] == cons_s2_reg[fill_sel_reg]);

   // pin and toggle synchronisers, frozen with the clock enable
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         {cs_s1_reg, cs_s2_reg} <= 2'h3;
         {hw_s1_reg, hw_s2_reg} <= 2'h3;
         {ca_s1_reg, ca_s2_reg, ca_s3_reg} <= 3'h0;
         {wr_s1_reg, wr_s2_reg, wr_s3_reg} <= 3'h0;
         cons_s1_reg <= 2'h0;
         cons_s2_reg <= 2'h0;
         {und_s1_reg, und_s2_reg} <= 2'h0;
      end else if (i_clk_en) begin
         {cs_s1_reg, cs_s2_reg} <= {i_chip_select_n, cs_s1_reg};
         {hw_s1_reg, hw_s2_reg} <= {i_hw_reset_n, hw_s1_reg};
         {ca_s1_reg, ca_s2_reg, ca_s3_reg} <= {ca_tog_reg, ca_s1_reg, ca_s2_reg};
         {wr_s1_reg, wr_s2_reg, wr_s3_reg} <= {wr_tog_reg, wr_s1_reg, wr_s2_reg};
         cons_s1_reg <= cons_tog_reg;
         cons_s2_reg <= cons_s1_reg;
         {und_s1_reg, und_s2_reg} <= {underrun_reg, und_s1_reg};
      end
   end

   // command report and write words; link words are stable long past the toggle
   always_ff @(posedge i_clk) begin
      if (sys_rst) begin
         o_cmd       <= '0;
         o_cmd_valid <= 1'b0;
         o_wr        <= '0;
         o_wr_valid  <= 1'b0;
         reading_reg <= 1'b0;
      end else if (i_clk_en) begin
         o_cmd_valid <= ca_s2_reg ^ ca_s3_reg;
         o_wr_valid  <= wr_s2_reg ^ wr_s3_reg;
         if (ca_s2_reg ^ ca_s3_reg) begin
            o_cmd       <= '{cmd: cmd_reg, addr: addr_reg};
            reading_reg <= is_read(cmd_reg);
         end else if (cs_s2_reg) begin
            reading_reg <= 1'b0;
         end
         if (wr_s2_reg ^ wr_s3_reg) begin
            o_wr <= wr_word_reg;  // mask high: array byte left as is
         end
      end
   end

   // read slots: ping-pong pair refilled from the FIFO; outside a read the
   // fill flags follow the consume flags so both slots read as empty
   always_ff @(posedge i_clk) begin
      if (sys_rst) begin
         fill_sel_reg <= 1'b0;
         fill_tog_reg <= 2'h0;
         slot_reg[0]  <= 16'h0000;
         slot_reg[1]  <= 16'h0000;
      end else if (i_clk_en) begin
         if (!reading_reg) begin
            fill_sel_reg <= 1'b0;
            fill_tog_reg <= cons_s2_reg;
         end else if (fifo_pop) begin
            slot_reg[fill_sel_reg]     <= fifo_data;
            fill_tog_reg[fill_sel_reg] <= ~fill_tog_reg[fill_sel_reg];
            fill_sel_reg               <= ~fill_sel_reg;
         end
      end
   end

   // status flags
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_busy          <= 1'b0;
         o_standby       <= 1'b1;
         o_read_underrun <= 1'b0;
      end else if (i_clk_en) begin
         o_busy          <= ~cs_s2_reg;
         o_standby       <= ~hw_s2_reg;
         o_read_underrun <= und_s2_reg;
      end
   end

   // read data buffer; flushed when the frame ends so no word leaks on
   odppi_fifo #(
      .WIDTH (`ODPPI_FIFO_WIDTH),
      .DEPTH (`ODPPI_FIFO_DEPTH)
   ) u_rd_fifo (
      .i_clk    (i_clk),
      .i_reset  (sys_rst),
      .i_clk_en (i_clk_en),
      .i_flush  (cs_s2_reg),
      .i_valid  (i_rd_valid),
      .o_ready  (o_rd_ready),
      .i_data   (i_rd_data),
      .o_valid  (fifo_valid),
      .i_ready  (fifo_pop),
      .o_data   (fifo_data)
   );
   // complement clock has no digital use here
   wire logic unused_ok = i_bus_clock_complement;

endmodule : odppi_pin_if

`default_nettype wire

// >>> verification/odppi_pin_if_properties.sv
// Purpose: port-level checks of the octal DDR pin interface
// Assumes: i_clk far faster than the bus clock, so pins settle between edges
// Notes:   drivers clear without a clock; i_clk sampling still sees it
`default_nettype none

module odppi_pin_if_properties (
   // clock and control
   input wire logic i_clk,
   input wire logic i_reset,
   // memory pins
   input wire logic i_bus_clock_true,
   input wire logic i_chip_select_n,
   input wire logic i_hw_reset_n,
   input wire logic o_dq_oe,
   input wire logic o_read_write_strobe,
   input wire logic o_read_write_strobe_oe,
   // user side
   input wire logic o_cmd_valid,
   input wire logic o_wr_valid,
   input wire logic o_busy,
   input wire logic o_standby,
   input wire logic o_read_underrun
);
   // all checks live in the system clock domain
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);

   chk_cs_release: assert property (i_chip_select_n |-> !o_dq_oe && !o_read_write_strobe_oe)
      else $error("pins driven while deselected");
   chk_pin_release: assert property (!i_hw_reset_n |-> !o_dq_oe && !o_read_write_strobe_oe)
      else $error("pins driven while reset pin low");
   chk_busy_start: assert property ($fell(i_chip_select_n) |-> ##[1:4] o_busy)
      else $error("select fall did not start a frame");
   chk_busy_end: assert property ($rose(i_chip_select_n) |-> ##[1:4] !o_busy)
      else $error("select rise did not end the frame");
   chk_standby_enter: assert property ($fell(i_hw_reset_n) |-> ##[1:4] o_standby)
      else $error("reset pin did not enter standby");
   chk_standby_quiet: assert property (o_standby |-> !o_cmd_valid && !o_wr_valid)
      else $error("traffic reported in standby");
   chk_read_strobe: assert property (o_dq_oe |->
         o_read_write_strobe_oe && o_read_write_strobe == i_bus_clock_true)
      else $error("read strobe not edge aligned with data");
   chk_write_input: assert property (o_wr_valid |-> !o_read_write_strobe_oe && !o_dq_oe)
      else $error("device drives pins in write data");
   chk_oe_launch: assert property ($rose(o_dq_oe) |->
         !i_chip_select_n && i_hw_reset_n && i_bus_clock_true)
      else $error("data drive began off a rising edge");

   // main scenarios reached
   cover property (o_cmd_valid);
   cover property (o_wr_valid);
   cover property ($rose(o_dq_oe));
   cover property (o_read_underrun);
endmodule : odppi_pin_if_properties

`default_nettype wire

// >>> verification/odppi_host_model.sv
// Purpose: host controller framing transfers on the octal DDR bus
// Assumes: bus clock of 160 ns, parked low between frames
// Notes:   bytes change mid half-period so both edges see settled data
`default_nettype none
`include "odppi_params.svh"

module odppi_host_model (
   // host driven pins
   output logic       o_bus_clock_true,
   output logic       o_bus_clock_complement,
   output logic       o_chip_select_n,
   output logic [7:0] o_dq,
   output logic       o_dq_oe,
   output logic       o_strobe,
   output logic       o_strobe_oe,
   // resolved bus levels
   input  wire logic [7:0] i_dq,
   input  wire logic       i_strobe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [17:0] wq [$];   // write words {mask, data}, filled by the bench
   logic [15:0] rd_q [$]; // captured read words
   logic        lat_hi;   // strobe level seen in address cycles
   logic        strobe_ok;

   // idle bus: clock stopped, nothing selected
   initial begin
      {o_bus_clock_true, o_chip_select_n, o_bus_clock_complement} = 3'h3;
      {o_dq, o_dq_oe, o_strobe, o_strobe_oe} = 11'h000;
   end

   // one bus clock: high byte on the rise, low byte on the fall
   task automatic cycle(input logic [17:0] w, output logic [15:0] r, output logic [1:0] s);
      o_dq = w[15:8];
      o_strobe = w[17];
      #40 o_bus_clock_true = 1'b1;
      o_bus_clock_complement = 1'b0; // complement follows the true clock
      #40 r[15:8] = i_dq;
      s[1] = i_strobe;
      o_dq = w[7:0];
      o_strobe = w[16];
      #40 o_bus_clock_true = 1'b0;
      o_bus_clock_complement = 1'b1;
      #40 r[7:0] = i_dq;
      s[0] = i_strobe;
   endtask : cycle

   // a whole frame on this device's own select line
   task automatic xfer(input logic [7:0] op, input logic [31:0] a, input int n);
      logic        rd;
      logic        lat;
      logic [15:0] r;
      logic [1:0]  s;
      rd = op inside {`ODPPI_OP_READ, `ODPPI_OP_RDREG, `ODPPI_OP_RDID};
      lat = rd || op == `ODPPI_OP_WRITE;
      rd_q.delete();
      strobe_ok = 1'b1;
      #1.3 o_chip_select_n = 1'b0;
      o_dq_oe = 1'b1;
      #40 cycle({2'h0, op, op}, r, s);
      cycle({2'h0, a[31:16]}, r, s);
      lat_hi = s[1];
      strobe_ok &= s[1] == s[0];
      cycle({2'h0, a[15:0]}, r, s);
      o_dq_oe = !rd;
      // a high strobe in address cycles doubles the wait
      if (lat) repeat (lat_hi ? `ODPPI_LAT_2X : `ODPPI_LAT_1X) cycle(18'h00000, r, s);
      o_strobe_oe = !rd && (lat || op == `ODPPI_OP_WRREG); // byte mask
      for (int i = 0; i < n; i++) begin
         cycle(rd ? 18'h00000 : wq[i], r, s);
         if (rd) rd_q.push_back(r);
         if (rd) strobe_ok &= s == 2'h2;
      end
      #40 o_chip_select_n = 1'b1; // clock idle before deselect
      o_dq_oe = 1'b0;
      o_strobe_oe = 1'b0;
      #200;
   endtask : xfer
endmodule : odppi_host_model

`default_nettype wire

// >>> verification/octal_ddr_psram_pin_interface_test.sv
// Purpose: self-checking bench of the octal DDR pin interface
// Assumes: host model frames every transfer; bench plays the array side
// Notes:   read words are fed only after the command report, as an array would
`default_nettype none
`include "odppi_params.svh"

module octal_ddr_psram_pin_interface_test import odppi_pkg::*; ();
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk = 1'b0, i_reset = 1'b1, i_hw_reset_n = 1'b1;
   logic i_refresh_pending = 1'b0, i_rd_valid = 1'b0;
   logic [15:0] i_rd_data = 16'h0000;
   logic [7:0] h_dq, d_dq, pat = 8'h5A;
   logic h_clk, h_clkc, h_cs_n, h_dq_oe, h_st, h_st_oe, d_dq_oe, d_st, d_st_oe;
   logic o_cmd_valid, o_wr_valid, o_rd_ready, o_busy, o_standby, o_read_underrun;
   wire logic [7:0] dq_w;
   wire logic st_w;
   odppi_ca_t o_cmd, last_cmd;
   odppi_wr_t o_wr;
   odppi_wr_t wr_q [$];
   logic [15:0] feed [32];
   logic [7:0] rd_ops [3] = '{`ODPPI_OP_READ, `ODPPI_OP_RDREG, `ODPPI_OP_RDID};
   int fi, fn, bad_count, total_checks, cycles;
   logic feed_go, saw_full, prev_pend;

   // released lines show a changing pattern, never the last driven byte
   assign dq_w = d_dq_oe ? d_dq : h_dq_oe ? h_dq : pat;
   assign st_w = d_st_oe ? d_st : h_st_oe ? h_st : pat[0];
   always #2 i_clk = ~i_clk;

   odppi_pin_if dut (.i_clk(i_clk), .i_reset(i_reset), .i_clk_en(1'b1),
      .i_bus_clock_true(h_clk), .i_bus_clock_complement(h_clkc),
      .i_chip_select_n(h_cs_n), .i_hw_reset_n(i_hw_reset_n), .i_dq(dq_w),
      .o_dq(d_dq), .o_dq_oe(d_dq_oe), .i_read_write_strobe(st_w),
      .o_read_write_strobe(d_st), .o_read_write_strobe_oe(d_st_oe),
      .i_refresh_pending(i_refresh_pending), .o_cmd(o_cmd), .o_cmd_valid(o_cmd_valid),
      .o_wr(o_wr), .o_wr_valid(o_wr_valid), .i_rd_data(i_rd_data),
      .i_rd_valid(i_rd_valid), .o_rd_ready(o_rd_ready), .o_busy(o_busy),
      .o_standby(o_standby), .o_read_underrun(o_read_underrun));
   odppi_host_model host (.o_bus_clock_true(h_clk), .o_bus_clock_complement(h_clkc),
      .o_chip_select_n(h_cs_n), .o_dq(h_dq), .o_dq_oe(h_dq_oe), .o_strobe(h_st),
      .o_strobe_oe(h_st_oe), .i_dq(dq_w), .i_strobe(st_w));

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t ns: seen %0h, expected %0h", $time, seen, exp);
      end
   endtask : check

   task automatic test_done();
      $display("checks %0d, mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : test_done

   // array side: feed read words, log reports, bound the run length
   always @(posedge i_clk) begin
      cycles++;
      pat <= pat + 8'h3B;
      if (i_rd_valid && o_rd_ready) fi++;
      if (o_cmd_valid === 1'b1) feed_go = 1'b1;
      if (o_cmd_valid === 1'b1) last_cmd = o_cmd;
      if (o_rd_ready === 1'b0) saw_full = 1'b1;
      if (o_wr_valid === 1'b1) wr_q.push_back(o_wr);
      i_rd_valid <= feed_go && fi < fn;
      i_rd_data <= feed[fi[4:0]];
      if (cycles == 30000) bad_count++;
      if (cycles == 30000) test_done();
   end

   // one framed transfer and what it must produce
   task automatic run(input logic [7:0] op, input int n, input int nfeed);
      logic [31:0] a;
      logic        rd;
      a = $urandom;
      rd = op inside {`ODPPI_OP_READ, `ODPPI_OP_RDREG, `ODPPI_OP_RDID};
      @(negedge i_clk);
      {fn, fi, feed_go, saw_full, last_cmd} = '0;
      wr_q.delete();
      host.wq.delete();
      for (int i = 0; i < 32; i++) feed[i] = 16'($urandom);
      for (int i = 0; i < n; i++) host.wq.push_back(18'($urandom));
      fn = nfeed;
      @(posedge i_clk) i_refresh_pending <= a[31];
      host.xfer(op, a, n);
      for (int i = 0; i < 20 && o_busy !== 1'b0; i++) @(posedge i_clk);
      check(last_cmd, {op, a});
      if (a[31] == prev_pend) check(host.lat_hi, a[31]);
      prev_pend = a[31];
      if (n <= nfeed || !rd) check(host.strobe_ok, 1'b1);
      for (int i = 0; rd && i < n && i < nfeed; i++) check(host.rd_q[i], feed[i]);
      if (!rd) check(wr_q.size(), op inside {`ODPPI_OP_WRITE, `ODPPI_OP_WRREG} ? n : 0);
      foreach (wr_q[i]) check(wr_q[i], {a, host.wq[i][15:0], host.wq[i][17:16]});
   endtask : run

   // main sequence: random traffic with corner cases among it
   initial begin
      void'($urandom(52122));
      i_hw_reset_n <= 1'b0;  // power-up pulse clears the link side
      repeat (8) @(posedge i_clk);
      i_reset <= 1'b0;
      i_hw_reset_n <= 1'b1;
      repeat (4) @(posedge i_clk);
      check({o_standby, o_busy, o_rd_ready}, 3'h1);
      for (int k = 0; k < 6; k++) run(rd_ops[k % 3], 1 + $urandom % 4, 8);
      $display("test reads done");
      for (int k = 0; k < 6; k++) run(k % 2 ? `ODPPI_OP_WRITE : `ODPPI_OP_WRREG, 1 + k % 4, 0);
      $display("test writes done");
      run(8'h06, 3, 0);
      run(8'hB9, 2, 0);
      $display("test plain commands done");
      run(`ODPPI_OP_READ, 20, 20);
      check(saw_full, 1'b1);
      $display("test full buffer done");
      // starved read, then the reset pin cuts the frame short
      fork
         run(`ODPPI_OP_READ, 8, 2);
         begin
            repeat (825) @(posedge i_clk);
            check(o_read_underrun, 1'b1);
            i_hw_reset_n <= 1'b0;
            repeat (5) @(posedge i_clk);
            check({o_standby, d_dq_oe, d_st_oe}, 3'h4);
         end
      join
      i_hw_reset_n <= 1'b1;
      prev_pend = 1'bx;
      repeat (6) @(posedge i_clk);
      check({o_standby, o_read_underrun}, 2'h0);
      run(`ODPPI_OP_READ, 2, 8);
      $display("test reset pin done");
      test_done();
   end
endmodule : octal_ddr_psram_pin_interface_test

bind odppi_pin_if odppi_pin_if_properties u_props (.i_clk, .i_reset, .i_bus_clock_true,
   .i_chip_select_n, .i_hw_reset_n, .o_dq_oe, .o_read_write_strobe,
   .o_read_write_strobe_oe, .o_cmd_valid, .o_wr_valid, .o_busy, .o_standby,
   .o_read_underrun);

`default_nettype wire
